// ---- src/can_err_regs.vh ----
// register map, field layout and reset values of the error and time stamp block
`ifndef CAN_ERR_REGS_VH
`define CAN_ERR_REGS_VH

`define OFS_GLOBAL_CONFIG 8'h00
`define OFS_BIT_TIMING 8'h01
`define OFS_IRQ_ENABLE 8'h02
`define OFS_STATUS 8'h03
`define OFS_IRQ_CLEAR 8'h04
`define OFS_ERROR_COUNTS 8'h05
`define OFS_ERROR_DIAG 8'h06
`define OFS_TIME_STAMP 8'h07

`define CFG_ENABLE_BIT 0
`define CFG_TX_POL_BIT 1
`define CFG_RX_POL_BIT 2
`define CFG_STAMP_CLR_BIT 3
`define CFG_WIDTH 4
`define CFG_RESET 4'h0

`define TIMING_RESET 16'h0000
`define IRQ_ENABLE_BIT 0
`define IRQ_PENDING_BIT 0
`define IRQ_CLEAR_BIT 0
`define STAT_NODE_LSB 5

`define REC_MSB 15
`define REC_LSB 8
`define TEC_MSB 7
`define TEC_LSB 0

`define DIAG_FIELD_LSB 0
`define DIAG_INDEX_LSB 4
`define DIAG_TXE_BIT 10
`define DIAG_STUFF_BIT 11
`define DIAG_CRC_BIT 12
`define DIAG_MON_BIT 13
`define DIAG_DRIVE_BIT 14
`define DIAG_RESET 16'h0000

`define STAMP_RESET 16'h0000
`define COUNTS_RESET 16'h0000
`define REC_RESET 8'h00
`define TEC_RESET 8'h00

`define NODE_OFF 3'h0
`define NODE_ACTIVE 3'h2
`define NODE_WARNING 3'h3
`define NODE_PASSIVE 3'h4
`define NODE_BUS_OFF 3'h6
`define WARN_LIMIT 8'h60
`define PASSIVE_LIMIT 8'h80

`define FIELD_ACK 4'h4
`define RECESSIVE 1'b1

`endif

// ---- src/can_error_diag_timestamp.v ----
// error counters, last error diagnosis, bit time stamp and pin polarity
//
// Local design decisions: the register addresses and the plain strobed port.
`include "can_err_regs.vh"
`default_nettype none
module can_error_diag_timestamp #(
    parameter BUF_COUNT = 15,
    parameter BUF_AW = 4,
    parameter STAMP_W = 16
) (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire bus_rx_pin,
    output reg bus_tx_pin,
    input wire tx_bit,
    output reg rx_bit,
    input wire bit_tick,
    input wire field_start,
    input wire [3:0] field_code_in,
    input wire [5:0] field_len,
    input wire error_detect,
    input wire stuff_error,
    input wire crc_error,
    input wire transmitting,
    input wire [7:0] rx_error_count_in,
    input wire [7:0] tx_error_count_in,
    input wire bus_off,
    input wire frame_done,
    input wire [BUF_AW-1:0] frame_buf,
    input wire [BUF_AW-1:0] stamp_rd_idx,
    output wire [STAMP_W-1:0] stamp_rd_data,
    output reg controller_enable,
    output reg [15:0] bit_timing,
    output reg [2:0] node_state,
    output reg error_irq
);
    reg [`CFG_WIDTH-1:0] global_config_reg;
    reg [15:0] bit_timing_reg;
    reg error_irq_enable_reg;
    reg error_irq_pending_reg;
    reg [7:0] rx_error_count_reg;
    reg [7:0] tx_error_count_reg;
    reg [15:0] last_error_diagnosis_reg;
    reg [STAMP_W-1:0] bit_time_stamp_reg;
    reg [STAMP_W-1:0] bit_time_stamp_next;
    reg [3:0] field_code_reg;
    reg [5:0] bit_index_reg;
    reg [5:0] bit_index_next;
    reg rx_meta_reg;
    reg rx_sync_reg;
    reg [15:0] rdata_next;
    reg pending_next;
    reg [15:0] diag_next;
    wire irq_next = pending_next && error_irq_enable_reg;

    wire cfg_enable = global_config_reg[`CFG_ENABLE_BIT];
    wire cfg_tx_pol = global_config_reg[`CFG_TX_POL_BIT];
    wire cfg_rx_pol = global_config_reg[`CFG_RX_POL_BIT];
    wire cfg_stamp_clr = global_config_reg[`CFG_STAMP_CLR_BIT];
    wire wr_cfg = reg_wr && (reg_addr == `OFS_GLOBAL_CONFIG);
    wire wr_timing = reg_wr && (reg_addr == `OFS_BIT_TIMING);
    wire wr_irq_en = reg_wr && (reg_addr == `OFS_IRQ_ENABLE);
    wire wr_irq_clr = reg_wr && (reg_addr == `OFS_IRQ_CLEAR);
    wire counts_change = (rx_error_count_in != rx_error_count_reg) ||
        (tx_error_count_in != tx_error_count_reg);
    wire stamp_buf0_clear = frame_done && cfg_stamp_clr &&
        (frame_buf == {BUF_AW{1'b0}});

    // fault confinement level from counters
    function [2:0] node_of;
        input en;
        input off;
        input [7:0] rx_error_count;
        input [7:0] tx_error_count;
        begin
            if (!en) begin
                node_of = `NODE_OFF;
            end else if (off) begin
                node_of = `NODE_BUS_OFF;
            end else if (rx_error_count >= `PASSIVE_LIMIT || tx_error_count >= `PASSIVE_LIMIT) begin
                node_of = `NODE_PASSIVE;
            end else if (rx_error_count >= `WARN_LIMIT || tx_error_count >= `WARN_LIMIT) begin
                node_of = `NODE_WARNING;
            end else begin
                node_of = `NODE_ACTIVE;
            end
        end
    endfunction

    // receive pin synchroniser
    always @(posedge clk) begin
        if (sys_rst) begin
            rx_meta_reg <= `RECESSIVE;
            rx_sync_reg <= `RECESSIVE;
        end else begin
            rx_meta_reg <= bus_rx_pin;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            rx_bit <= `RECESSIVE;
            bus_tx_pin <= `RECESSIVE;
        end else begin
            rx_bit <= cfg_enable ? (rx_sync_reg ^ cfg_rx_pol) : `RECESSIVE;
            bus_tx_pin <= (cfg_enable ? tx_bit : `RECESSIVE) ^ cfg_tx_pol;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            global_config_reg <= `CFG_RESET;
            bit_timing_reg <= `TIMING_RESET;
            error_irq_enable_reg <= 1'b0;
        end else begin
            if (wr_cfg) begin
                global_config_reg <= reg_wdata[`CFG_WIDTH-1:0];
            end
            if (wr_timing) begin
                bit_timing_reg <= reg_wdata;
            end
            if (wr_irq_en) begin
                error_irq_enable_reg <= reg_wdata[`IRQ_ENABLE_BIT];
            end
        end
    end

    always @* begin
        pending_next = error_irq_pending_reg;
        if (wr_irq_clr && reg_wdata[`IRQ_CLEAR_BIT]) begin
            pending_next = 1'b0;
        end
        // a change in the clear cycle still wins
        if (error_irq_enable_reg && counts_change) begin
            pending_next = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            rx_error_count_reg <= `REC_RESET;
            tx_error_count_reg <= `TEC_RESET;
            error_irq_pending_reg <= 1'b0;
            error_irq <= 1'b0;
            node_state <= `NODE_OFF;
            controller_enable <= 1'b0;
            bit_timing <= `TIMING_RESET;
        end else begin
            rx_error_count_reg <= rx_error_count_in;
            tx_error_count_reg <= tx_error_count_in;
            error_irq_pending_reg <= pending_next;
            error_irq <= irq_next;
            node_state <= node_of(cfg_enable, bus_off, rx_error_count_in,
                tx_error_count_in);
            controller_enable <= cfg_enable;
            bit_timing <= bit_timing_reg;
        end
    end

    always @* begin
        bit_index_next = bit_index_reg;
        if (field_start) begin
            bit_index_next = field_len - 6'h01;
        end else if (bit_tick) begin
            bit_index_next = bit_index_reg - 6'h01;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            field_code_reg <= 4'h0;
            bit_index_reg <= 6'h00;
        end else begin
            if (field_start) begin
                field_code_reg <= field_code_in;
            end
            bit_index_reg <= bit_index_next;
        end
    end

    always @* begin
        diag_next = `DIAG_RESET;
        diag_next[`DIAG_FIELD_LSB +: 4] = field_code_reg;
        diag_next[`DIAG_INDEX_LSB +: 6] = bit_index_reg;
        diag_next[`DIAG_TXE_BIT] = transmitting;
        diag_next[`DIAG_STUFF_BIT] = stuff_error;
        diag_next[`DIAG_CRC_BIT] = crc_error;
        diag_next[`DIAG_MON_BIT] = rx_bit;
        diag_next[`DIAG_DRIVE_BIT] = bus_tx_pin;
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            last_error_diagnosis_reg <= `DIAG_RESET;
        end else if (error_detect) begin
            last_error_diagnosis_reg <= diag_next;
        end
    end

    always @* begin
        bit_time_stamp_next = bit_time_stamp_reg;
        if (stamp_buf0_clear) begin
            bit_time_stamp_next = `STAMP_RESET;
        end else if (bit_tick) begin
            bit_time_stamp_next = bit_time_stamp_reg + {{(STAMP_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            bit_time_stamp_reg <= `STAMP_RESET;
        end else begin
            bit_time_stamp_reg <= bit_time_stamp_next;
        end
    end

    // indexes past the last buffer must not reach the store
    wire stamp_wr_en = frame_done && (frame_buf < BUF_COUNT);
    // an absent slot reads as slot 0 rather than unknown
    wire [BUF_AW-1:0] stamp_rd_slot = (stamp_rd_idx < BUF_COUNT) ? stamp_rd_idx :
        {BUF_AW{1'b0}};

    stamp_memory #(
        .DEPTH(BUF_COUNT),
        .AW(BUF_AW),
        .DW(STAMP_W)
    ) stamp_store (
        .clk(clk),
        .wr_en(stamp_wr_en),
        .wr_addr(frame_buf),
        .wr_data(bit_time_stamp_reg),
        .rd_addr(stamp_rd_slot),
        .rd_data(stamp_rd_data)
    );

    // read-only registers have no write path
    always @* begin
        rdata_next = 16'h0000;
        case (reg_addr)
            `OFS_GLOBAL_CONFIG: begin
                rdata_next[`CFG_WIDTH-1:0] = global_config_reg;
            end
            `OFS_BIT_TIMING: begin
                rdata_next = bit_timing_reg;
            end
            `OFS_IRQ_ENABLE: begin
                rdata_next[`IRQ_ENABLE_BIT] = error_irq_enable_reg;
            end
            `OFS_STATUS: begin
                rdata_next[`IRQ_PENDING_BIT] = error_irq_pending_reg;
                rdata_next[`STAT_NODE_LSB +: 3] = node_state;
            end
            `OFS_ERROR_COUNTS: begin
                rdata_next[`REC_MSB:`REC_LSB] = rx_error_count_reg;
                rdata_next[`TEC_MSB:`TEC_LSB] = tx_error_count_reg;
            end
            `OFS_ERROR_DIAG: begin
                rdata_next = last_error_diagnosis_reg;
            end
            `OFS_TIME_STAMP: begin
                rdata_next = bit_time_stamp_reg[15:0];
            end
            default: begin
                rdata_next = 16'h0000;
            end
        endcase
    end

    // data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule // can_error_diag_timestamp
`default_nettype wire

// ---- src/stamp_memory.v ----
// per-buffer time stamp store, registered read port
`default_nettype none
module stamp_memory #(
    parameter DEPTH = 15,
    parameter AW = 4,
    parameter DW = 16
) (
    input wire clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:DEPTH-1];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        // no reset on contents; reader asks only for stored slots
        rd_data <= mem[rd_addr];
    end
endmodule // stamp_memory
`default_nettype wire

// ---- testbench/can_error_diag_timestamp_checker.sv ----
// port-level assertions for the error, diagnosis and stamp block
`default_nettype none
module can_error_diag_timestamp_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic rx_bit,
    input wire logic controller_enable,
    input wire logic error_detect,
    input wire logic stuff_error,
    input wire logic crc_error,
    input wire logic transmitting,
    input wire logic [7:0] rx_error_count_in,
    input wire logic [7:0] tx_error_count_in,
    input wire logic bus_off,
    input wire logic [2:0] node_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dclk @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire logic [7:0] rc = rx_error_count_in;
    wire logic [7:0] tc = tx_error_count_in;
    wire logic low = rc < 8'h60 && tc < 8'h60;
    wire logic mid = !low && rc < 8'h80 && tc < 8'h80;
    // error pulse, then a diagnosis read on the very next edge
    sequence s_err_read;
        error_detect ##1 (reg_rd && reg_addr == 8'h06 && !error_detect);
    endsequence
    AST_COUNTS_READ: assert property (reg_rd && reg_addr == 8'h05 && $stable(rc)
        && $stable(tc) |=> reg_rdata == {$past(rc), $past(tc)})
        else $error("count register mismatch");
    AST_DIAG_TXE: assert property (s_err_read
        |=> reg_rdata[10] == $past(transmitting, 2)) else $error("transmitter flag wrong");
    AST_DIAG_STUFF: assert property (s_err_read
        |=> reg_rdata[11] == $past(stuff_error, 2)) else $error("stuffing flag wrong");
    AST_DIAG_CRC: assert property (s_err_read
        |=> reg_rdata[12] == $past(crc_error, 2)) else $error("crc flag wrong");
    AST_RX_BLOCKED: assert property (!controller_enable [*3] |-> rx_bit)
        else $error("receive not blocked while disabled");
    AST_NODE_ACTIVE: assert property ((controller_enable && !bus_off && low) [*3]
        |-> node_state == 3'h2) else $error("node not error active");
    AST_NODE_WARN: assert property ((controller_enable && !bus_off && mid) [*3]
        |-> node_state == 3'h3) else $error("node not at warning");
    AST_NODE_OFF: assert property ((controller_enable && bus_off) [*3]
        |-> node_state == 3'h6) else $error("node not bus off");
endmodule // can_error_diag_timestamp_checker
`default_nettype wire

// ---- testbench/can_error_diag_timestamp_tb_top.sv ----
// self-checking bench for the error, diagnosis and stamp block
`default_nettype none
module can_error_diag_timestamp_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [3:0] c; logic [5:0] l; int n; logic [3:0] f; logic [15:0] e;} row_t;
    logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, tx_bit = 1, bit_tick = 0;
    logic field_start = 0, error_detect = 0, stuff_error = 0, crc_error = 0, transmitting = 0;
    logic bus_off = 0, frame_done = 0, force_dom = 0;
    logic bus_rx_pin, bus_tx_pin, rx_bit, controller_enable, error_irq;
    logic [7:0] reg_addr = 0, rx_in = 8'h12, tx_in = 8'h34;
    logic [15:0] reg_wdata = 0, reg_rdata, q, stamp_rd_data, bit_timing;
    logic [3:0] code = 0, frame_buf = 0, stamp_rd_idx = 0;
    logic [5:0] flen = 0;
    logic [2:0] node_state;
    int miscompares = 0, checks_done = 0;
    // flags f: stuff, crc, transmitting, driven bit
    row_t rows [4] = '{'{4'hE, 6'd40, 3, 4'b1010, 16'h0E4E}, '{4'h4, 6'd1, 0, 4'b0101, 16'h7004},
        '{4'hF, 6'd15, 14, 4'b0011, 16'h640F}, '{4'h0, 6'd63, 0, 4'b1100, 16'h1BE0}};
    always #5 clk = ~clk;
    can_transceiver_model u_xcvr (.txd(bus_tx_pin), .force_dom(force_dom), .rxd(bus_rx_pin));
    can_error_diag_timestamp u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin), .tx_bit(tx_bit), .rx_bit(rx_bit),
        .bit_tick(bit_tick), .field_start(field_start), .field_code_in(code), .field_len(flen),
        .error_detect(error_detect), .stuff_error(stuff_error), .crc_error(crc_error),
        .transmitting(transmitting), .rx_error_count_in(rx_in), .tx_error_count_in(tx_in),
        .bus_off(bus_off), .frame_done(frame_done), .frame_buf(frame_buf),
        .stamp_rd_idx(stamp_rd_idx), .stamp_rd_data(stamp_rd_data),
        .controller_enable(controller_enable), .bit_timing(bit_timing), .node_state(node_state),
        .error_irq(error_irq));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_of_test;
        if (miscompares == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 q = reg_rdata;
    endtask
    // field start, n bit ticks, error, then diagnosis read on the next edge
    task fld(input logic [3:0] c, input logic [5:0] l, input int n, input logic [3:0] f);
        @(posedge clk);
        {stuff_error, crc_error, transmitting, tx_bit} <= f;
        cyc(4);
        field_start <= 1;
        code <= c;
        flen <= l;
        repeat (n) begin
            @(posedge clk);
            field_start <= 0;
            bit_tick <= 1;
        end
        @(posedge clk);
        {field_start, bit_tick, error_detect} <= 3'b001;
        @(posedge clk);
        error_detect <= 0;
        reg_rd <= 1;
        reg_addr <= 8'h06;
        @(posedge clk);
        reg_rd <= 0;
        #1 q = reg_rdata;
    endtask
    task nst(input logic [7:0] r, input logic b, input logic [2:0] e);
        @(posedge clk);
        rx_in <= r;
        bus_off <= b;
        cyc(4);
        chk("node_state", node_state, e);
    endtask
    initial begin
        #100000;
        miscompares++;
        end_of_test();
    end
    initial begin
        cyc(5);
        sys_rst <= 0;
        rd(8'h06); chk("diag reset", q, 16'h0000);
        rd(8'h07); chk("stamp reset", q, 16'h0000);
        rd(8'h05); chk("counts", q, 16'h1234);
        rd(8'hFF); chk("unmapped", q, 16'h0000);
        wr(8'h01, 16'h0A5C);
        rd(8'h01);
        chk("timing read", q, 16'h0A5C);
        chk("timing out", bit_timing, 16'h0A5C);
        wr(8'h00, 16'h0001);
        @(posedge clk);
        bit_tick <= 1;
        cyc(5);
        bit_tick <= 0;
        rd(8'h07); chk("stamp count", q, 16'h0005);
        @(posedge clk);
        {frame_done, frame_buf, stamp_rd_idx} <= {1'b1, 4'h3, 4'h3};
        @(posedge clk);
        frame_done <= 0;
        cyc(2); chk("slot 3", stamp_rd_data, 16'h0005);
        // stamp clear enable with buffer 0 transfer
        wr(8'h00, 16'h0009);
        @(posedge clk);
        {frame_done, frame_buf, stamp_rd_idx} <= 9'h100;
        @(posedge clk);
        frame_done <= 0;
        wr(8'h07, 16'hFFFF);
        rd(8'h07); chk("stamp cleared", q, 16'h0000);
        chk("slot 0", stamp_rd_data, 16'h0005);
        wr(8'h05, 16'hFFFF);
        wr(8'h06, 16'hFFFF);
        rd(8'h05); chk("counts kept", q, 16'h1234);
        rd(8'h06); chk("diag kept", q, 16'h0000);
        @(posedge clk);
        tx_bit <= 0;
        wr(8'h00, 16'h0007);
        cyc(5); chk("tx inverted", bus_tx_pin, 1);
        chk("rx inverted", rx_bit, 0);
        wr(8'h00, 16'h0005);
        cyc(5); chk("tx plain", bus_tx_pin, 0);
        chk("rx inverted only", rx_bit, 1);
        rd(8'h03);
        chk("idle status", q, 16'h0040);
        wr(8'h00, 16'h0000);
        @(posedge clk);
        force_dom <= 1;
        cyc(5); chk("tx disabled", bus_tx_pin, 1);
        chk("rx disabled", rx_bit, 1);
        @(posedge clk);
        force_dom <= 0;
        wr(8'h00, 16'h0001);
        chk("timing kept", bit_timing, 16'h0A5C);
        foreach (rows[i]) begin
            fld(rows[i].c, rows[i].l, rows[i].n, rows[i].f);
            chk("diag row", q, rows[i].e);
        end
        for (int c = 0; c < 16; c++) begin
            fld(c[3:0], c[5:0] + 6'd1, 0, 4'b0001);
            chk("field code", q, 16'h6000 | (c << 4) | c);
        end
        nst(8'h12, 0, 3'h2);
        nst(8'h60, 0, 3'h3);
        nst(8'h80, 0, 3'h4);
        nst(8'h12, 1, 3'h6);
        nst(8'h12, 0, 3'h2);
        wr(8'h02, 16'h0001);
        @(posedge clk);
        tx_in <= 8'h35;
        cyc(4); chk("irq raised", error_irq, 1);
        rd(8'h03);
        chk("status pending", q, 16'h0041);
        // clear and counter change in one cycle: set wins
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata, tx_in} <= {1'b1, 8'h04, 16'h0001, 8'h36};
        @(posedge clk);
        reg_wr <= 0;
        cyc(2);
        chk("set beats clear", error_irq, 1);
        wr(8'h04, 16'h0001);
        cyc(3); chk("irq cleared", error_irq, 0);
        // second reset in mid-run
        @(posedge clk);
        sys_rst <= 1;
        cyc(2);
        sys_rst <= 0;
        rd(8'h06); chk("diag reset again", q, 16'h0000);
        chk("enable reset", controller_enable, 0);
        end_of_test();
    end
endmodule // can_error_diag_timestamp_tb_top
bind can_error_diag_timestamp can_error_diag_timestamp_checker u_chk (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_bit(rx_bit), .controller_enable(controller_enable), .error_detect(error_detect),
    .stuff_error(stuff_error), .crc_error(crc_error), .transmitting(transmitting),
    .rx_error_count_in(rx_error_count_in), .tx_error_count_in(tx_error_count_in),
    .bus_off(bus_off), .node_state(node_state));
`default_nettype wire

// ---- testbench/can_transceiver_model.sv ----
// behavioural bus transceiver: wired bus line echoed back to the receive pin
`default_nettype none
module can_transceiver_model (
    input wire logic txd,
    input wire logic force_dom,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    // low is dominant, so another node can always pull the line down
    assign #2 rxd = txd & ~force_dom;
endmodule // can_transceiver_model
`default_nettype wire
